// file: core/faj_params.svh
/*
  Numeric constants of the fastening angle judgment block: widths, limits,
  selector codes and report masks. Definitions only; included by bare name.
*/
`ifndef FAJ_PARAMS_SVH
`define FAJ_PARAMS_SVH

// ==========================================================
// widths
`define FAJ_ANG_W 10
`define FAJ_CNT_W 14
`define FAJ_TRQ_W 14
`define FAJ_SYNC_W 3

// ==========================================================
// limits and saturation
`define FAJ_CNT_SAT 14'h3FFF
`define FAJ_TRQ_MAX 14'h270E
`define FAJ_ANG_OFF 10'h000
`define FAJ_CNT_ZERO 14'h0000

// ==========================================================
// selector codes
`define FAJ_SEL_OFF 2'h0
`define FAJ_SEL_ERR 2'h1
`define FAJ_SEL_WARN 2'h2
`define FAJ_MODE_TRQ_ANG 3'h5
`define FAJ_MODE_ANG_TRQ 3'h6

// ==========================================================
// report masks: bit2 snug-to-end, bit1 start-to-snug, bit0 free-run
`define FAJ_RPT_SEL0 3'h4
`define FAJ_RPT_SEL1 3'h6
`define FAJ_RPT_SEL2 3'h5
`define FAJ_RPT_SEL3 3'h7

`endif

// file: core/faj_pkg.sv
/*
  Types shared by the angle judgment modules.
  Assumes nothing of its surroundings.
*/
package faj_pkg;
  // ==========================================================
  // phase of one tightening cycle
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_FREE,
    PH_SEAT,
    PH_FINAL,
    PH_DONE
  } faj_phase_t;
endpackage

// file: core/faj_angle_if.sv
/*
  Carrier between the judgment core and its angle segment counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

interface faj_angle_if;
  logic clr;
  logic pulse;
  faj_pkg::faj_phase_t phase;
  logic [`FAJ_CNT_W-1:0] free_cnt;
  logic [`FAJ_CNT_W-1:0] seat_cnt;
  logic [`FAJ_CNT_W-1:0] final_cnt;

  modport ctrl (output clr, output pulse, output phase,
                input free_cnt, input seat_cnt, input final_cnt);
  modport cnt (input clr, input pulse, input phase,
               output free_cnt, output seat_cnt, output final_cnt);
endinterface

// file: core/faj_sync.sv
/*
  Three-stage synchroniser for pin inputs; the output follows once the
  second and third stages agree. Assumes one clock and a clock enable.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

module faj_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: a change counts only once two stages agree, filtering glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: core/faj_angle_cnt.sv
/*
  Angle segment counter: one pulse is one degree, summed into the segment
  that the current phase selects. Assumes a clean single-cycle pulse.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

module faj_angle_cnt (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  faj_angle_if.cnt ai
);
  function automatic logic [`FAJ_CNT_W-1:0] sat_inc(input logic [`FAJ_CNT_W-1:0] v);
    sat_inc = (v == `FAJ_CNT_SAT) ? v : v + 1'b1;
  endfunction

  // counters saturate so a runaway tool still reads as over any limit
  always_ff @(posedge clk) begin
    if (rst || (ce && ai.clr)) begin
      ai.free_cnt <= `FAJ_CNT_ZERO;
      ai.seat_cnt <= `FAJ_CNT_ZERO;
      ai.final_cnt <= `FAJ_CNT_ZERO;
    end else if (ce && ai.pulse) begin
      case (ai.phase)
        faj_pkg::PH_FREE: begin
          ai.free_cnt <= sat_inc(ai.free_cnt);
        end
        faj_pkg::PH_SEAT: begin
          ai.seat_cnt <= sat_inc(ai.seat_cnt);
        end
        faj_pkg::PH_FINAL: begin
          ai.final_cnt <= sat_inc(ai.final_cnt);
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// file: core/faj_judge.sv
/*
  Fastening angle judgment: follows one tightening cycle through free run,
  start-to-snug and snug-to-end, judges the angles and drives pass, fail,
  valve close, buzzer and count-down.
  Assumes torque, start/cut levels, the snug timer expiry and the judgment
  strobe come from logic on the same clock; trigger, angle pulse and the
  reset terminal are pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

// Functional notes
// - angle below nonzero minimum fails at judgment
// - minimum zero disables the low check
// - angle above nonzero maximum fails
// - maximum zero disables the high check
// - high failure closes valve, sounds buzzer
// - fail output held until error reset
// - limit auto-reset clears at next start
// - reset input clears errors and fail
// - snug-to-end angle counts from valid snug level
// - snug torque error on timer expiry
// - selector one: snug torque error fails
// - selector two: snug fault warns, passes, counts
// - snug angle checked when enabled
// - snug angle below nonzero minimum flags
// - snug angle above nonzero maximum flags
// - snug warning gives pass and count-down
// - fastening auto-clear clears snug errors
// - report selector picks angle segments
// - report selector only in modes five, six
// - free-run below minimum: error or warning
// - free-run warning passes, error fails
// - stop angle value reserved and unused
// - verdict selector: off, error, warning
// - free-run minimum up to 9999
module faj_judge (
  // clock and control
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // pins from the tool and panel
  input wire logic TRIGGER_IN,
  input wire logic ANGLE_PULSE_IN,
  input wire logic RESET_IN,
  // torque path, same clock
  input wire logic [`FAJ_TRQ_W-1:0] TORQUE_VALUE,
  input wire logic [`FAJ_TRQ_W-1:0] START_TORQUE,
  input wire logic [`FAJ_TRQ_W-1:0] CUT_TORQUE,
  input wire logic SNUG_TIMER_DONE,
  input wire logic JUDGE_STROBE,
  // settings
  input wire logic [`FAJ_TRQ_W-1:0] SEATING_TORQUE_LEVEL,
  input wire logic [`FAJ_ANG_W-1:0] FINAL_ANGLE_MIN,
  input wire logic [`FAJ_ANG_W-1:0] FINAL_ANGLE_MAX,
  input wire logic [`FAJ_ANG_W-1:0] STOP_ANGLE_VALUE,
  input wire logic SEATING_ANGLE_CHECK_ENABLE,
  input wire logic [`FAJ_ANG_W-1:0] SEATING_ANGLE_MIN,
  input wire logic [`FAJ_ANG_W-1:0] SEATING_ANGLE_MAX,
  input wire logic [1:0] ANGLE_REPORT_SELECT,
  input wire logic [1:0] IDLE_ROTATION_CHECK_SELECT,
  input wire logic [`FAJ_CNT_W-1:0] IDLE_ROTATION_MIN,
  input wire logic [1:0] ANGLE_VERDICT_SELECT,
  input wire logic SNUG_TORQUE_CHECK_ENABLE,
  input wire logic LIMIT_AUTO_RESET,
  input wire logic FASTEN_ERR_AUTO_CLEAR,
  input wire logic [2:0] CONTROL_STRATEGY,
  // verdict outputs
  output logic FAIL_OUTPUT,
  output logic PASS_OUTPUT,
  output logic COUNT_DOWN,
  output logic VALVE_CLOSE,
  output logic BUZZER,
  output logic WARNING,
  // error flags
  output logic FINAL_LOW_ERR,
  output logic FINAL_HIGH_ERR,
  output logic SNUG_TORQUE_ERR,
  output logic SEAT_LOW_ERR,
  output logic SEAT_HIGH_ERR,
  output logic IDLE_ROT_ERR,
  // reported angles
  output logic [2:0] REPORT_MASK,
  output logic [`FAJ_CNT_W-1:0] REPORT_IDLE_ANGLE,
  output logic [`FAJ_CNT_W-1:0] REPORT_SEAT_ANGLE,
  output logic [`FAJ_CNT_W-1:0] REPORT_FINAL_ANGLE
);
  // ==========================================================
  // helpers
  function automatic logic below_min(input logic [`FAJ_CNT_W-1:0] v,
                                     input logic [`FAJ_CNT_W-1:0] lim);
    below_min = (lim != `FAJ_CNT_ZERO) && (v < lim);
  endfunction

  function automatic logic above_max(input logic [`FAJ_CNT_W-1:0] v,
                                     input logic [`FAJ_CNT_W-1:0] lim);
    above_max = (lim != `FAJ_CNT_ZERO) && (v > lim);
  endfunction

  function automatic logic [2:0] report_mask(input logic [1:0] sel, input logic [2:0] mode);
    if (mode != `FAJ_MODE_TRQ_ANG && mode != `FAJ_MODE_ANG_TRQ) begin
      report_mask = `FAJ_RPT_SEL0;
    end else if (sel == 2'h1) begin
      report_mask = `FAJ_RPT_SEL1;
    end else if (sel == 2'h2) begin
      report_mask = `FAJ_RPT_SEL2;
    end else if (sel == 2'h3) begin
      report_mask = `FAJ_RPT_SEL3;
    end else begin
      report_mask = `FAJ_RPT_SEL0;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [2:0] pins_s;
  logic trig_s;
  logic pulse_s;
  logic rst_key_s;
  logic trig_q;
  logic pulse_q;

  faj_sync #(.W(`FAJ_SYNC_W)) u_sync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .d({RESET_IN, ANGLE_PULSE_IN, TRIGGER_IN}),
    .q(pins_s)
  );

  assign trig_s = pins_s[0];
  assign pulse_s = pins_s[1];
  assign rst_key_s = pins_s[2];

  always_ff @(posedge CLK) begin
    if (RST) begin
      trig_q <= 1'b0;
      pulse_q <= 1'b0;
    end else if (CE) begin
      trig_q <= trig_s;
      pulse_q <= pulse_s;
    end
  end

  logic cycle_start;
  logic err_clear;
  assign cycle_start = trig_s && !trig_q;
  assign err_clear = rst_key_s;

  // ==========================================================
  // snug level acceptance
  // an out-of-range setting is refused and the last good one stays in use
  logic [`FAJ_TRQ_W-1:0] seat_lvl_q;
  logic seat_lvl_ok;
  assign seat_lvl_ok = (SEATING_TORQUE_LEVEL <= `FAJ_TRQ_MAX) &&
                       (SEATING_TORQUE_LEVEL > START_TORQUE) &&
                       (SEATING_TORQUE_LEVEL < CUT_TORQUE);

  always_ff @(posedge CLK) begin
    if (RST) begin
      seat_lvl_q <= `FAJ_TRQ_MAX;
    end else if (CE && seat_lvl_ok) begin
      seat_lvl_q <= SEATING_TORQUE_LEVEL;
    end
  end

  // ==========================================================
  // cycle phase
  faj_pkg::faj_phase_t phase_q;
  logic start_hit;
  logic snug_hit;
  assign start_hit = TORQUE_VALUE >= START_TORQUE;
  assign snug_hit = TORQUE_VALUE >= seat_lvl_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_q <= faj_pkg::PH_IDLE;
    end else if (CE) begin
      if (cycle_start) begin
        phase_q <= faj_pkg::PH_FREE;
      end else begin
        case (phase_q)
          faj_pkg::PH_FREE: begin
            if (start_hit) begin
              phase_q <= faj_pkg::PH_SEAT;
            end
          end
          faj_pkg::PH_SEAT: begin
            if (snug_hit) begin
              phase_q <= faj_pkg::PH_FINAL;
            end else if (JUDGE_STROBE) begin
              phase_q <= faj_pkg::PH_DONE;
            end
          end
          faj_pkg::PH_FINAL: begin
            if (JUDGE_STROBE) begin
              phase_q <= faj_pkg::PH_DONE;
            end
          end
          faj_pkg::PH_DONE: begin
            phase_q <= faj_pkg::PH_DONE;
          end
          default: begin
            phase_q <= faj_pkg::PH_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // angle counters
  faj_angle_if ai ();
  assign ai.clr = cycle_start;
  assign ai.pulse = pulse_s && !pulse_q;
  assign ai.phase = phase_q;

  faj_angle_cnt u_cnt (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .ai(ai)
  );

  // ==========================================================
  // judgment terms
  logic judge_now;
  logic verdict_err;
  logic verdict_warn;
  logic lo_hit;
  logic hi_live;
  logic seat_viol;
  logic idle_viol;
  logic snug_miss;
  logic [`FAJ_CNT_W-1:0] fmin;
  logic [`FAJ_CNT_W-1:0] fmax;

  // judged once at the strobe; a cycle that never left free run has no angle
  assign judge_now = JUDGE_STROBE &&
                     (phase_q == faj_pkg::PH_SEAT || phase_q == faj_pkg::PH_FINAL);
  assign verdict_err = ANGLE_VERDICT_SELECT == `FAJ_SEL_ERR;
  assign verdict_warn = ANGLE_VERDICT_SELECT == `FAJ_SEL_WARN;
  assign fmin = {4'h0, FINAL_ANGLE_MIN};
  assign fmax = {4'h0, FINAL_ANGLE_MAX};
  assign lo_hit = below_min(ai.final_cnt, fmin);
  assign hi_live = (phase_q == faj_pkg::PH_FINAL) && above_max(ai.final_cnt, fmax);
  assign seat_viol = SEATING_ANGLE_CHECK_ENABLE &&
                     (below_min(ai.seat_cnt, {4'h0, SEATING_ANGLE_MIN}) ||
                      above_max(ai.seat_cnt, {4'h0, SEATING_ANGLE_MAX}));
  assign idle_viol = ai.free_cnt < IDLE_ROTATION_MIN;
  assign snug_miss = SNUG_TORQUE_CHECK_ENABLE && SNUG_TIMER_DONE &&
                     (phase_q == faj_pkg::PH_FREE || phase_q == faj_pkg::PH_SEAT);

  // ==========================================================
  // limit errors: final angle low and high
  // set is placed after clear so an event in the clearing cycle survives
  always_ff @(posedge CLK) begin
    if (RST) begin
      FINAL_LOW_ERR <= 1'b0;
      FINAL_HIGH_ERR <= 1'b0;
    end else if (CE) begin
      if (err_clear || (cycle_start && LIMIT_AUTO_RESET)) begin
        FINAL_LOW_ERR <= 1'b0;
        FINAL_HIGH_ERR <= 1'b0;
      end
      if (verdict_err && judge_now && lo_hit) begin
        FINAL_LOW_ERR <= 1'b1;
      end
      if (verdict_err && hi_live) begin
        FINAL_HIGH_ERR <= 1'b1;
      end
    end
  end

  // ==========================================================
  // fastening errors: snug torque, snug angle, free run
  always_ff @(posedge CLK) begin
    if (RST) begin
      SNUG_TORQUE_ERR <= 1'b0;
      SEAT_LOW_ERR <= 1'b0;
      SEAT_HIGH_ERR <= 1'b0;
      IDLE_ROT_ERR <= 1'b0;
    end else if (CE) begin
      if (err_clear || (cycle_start && FASTEN_ERR_AUTO_CLEAR)) begin
        SNUG_TORQUE_ERR <= 1'b0;
        SEAT_LOW_ERR <= 1'b0;
        SEAT_HIGH_ERR <= 1'b0;
        IDLE_ROT_ERR <= 1'b0;
      end
      if (snug_miss && verdict_err) begin
        SNUG_TORQUE_ERR <= 1'b1;
      end
      // only ever set here, so a flag latched by an earlier cycle is kept until the reset key or fastening auto-clear
      if (judge_now && verdict_err && seat_viol && below_min(ai.seat_cnt, {4'h0, SEATING_ANGLE_MIN})) begin
        SEAT_LOW_ERR <= 1'b1;
      end
      if (judge_now && verdict_err && seat_viol && above_max(ai.seat_cnt, {4'h0, SEATING_ANGLE_MAX})) begin
        SEAT_HIGH_ERR <= 1'b1;
      end
      if (judge_now && IDLE_ROTATION_CHECK_SELECT == `FAJ_SEL_ERR && idle_viol) begin
        IDLE_ROT_ERR <= 1'b1;
      end
    end
  end

  // ==========================================================
  // warnings: cleared at each new cycle, since they carry no fail state
  logic warn_set;
  assign warn_set = (snug_miss && verdict_warn) ||
                    (judge_now && verdict_warn && (seat_viol || lo_hit)) ||
                    (verdict_warn && hi_live) ||
                    (judge_now && IDLE_ROTATION_CHECK_SELECT == `FAJ_SEL_WARN && idle_viol);

  always_ff @(posedge CLK) begin
    if (RST) begin
      WARNING <= 1'b0;
    end else if (CE) begin
      if (cycle_start || err_clear) begin
        WARNING <= 1'b0;
      end
      if (warn_set) begin
        WARNING <= 1'b1;
      end
    end
  end

  // ==========================================================
  // fail, pass and count-down
  logic any_err;
  assign any_err = FINAL_LOW_ERR || FINAL_HIGH_ERR || SNUG_TORQUE_ERR ||
                   SEAT_LOW_ERR || SEAT_HIGH_ERR || IDLE_ROT_ERR;

  always_ff @(posedge CLK) begin
    if (RST) begin
      FAIL_OUTPUT <= 1'b0;
    end else if (CE) begin
      FAIL_OUTPUT <= any_err;
    end
  end

  // judged one cycle after the strobe so the latched errors are settled
  logic judged_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      judged_q <= 1'b0;
    end else if (CE) begin
      judged_q <= judge_now;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PASS_OUTPUT <= 1'b0;
      COUNT_DOWN <= 1'b0;
    end else if (CE) begin
      COUNT_DOWN <= 1'b0;
      if (cycle_start || err_clear) begin
        PASS_OUTPUT <= 1'b0;
      end else if (judged_q && !any_err) begin
        PASS_OUTPUT <= 1'b1;
        COUNT_DOWN <= 1'b1;
      end
    end
  end

  // ==========================================================
  // valve and buzzer
  always_ff @(posedge CLK) begin
    if (RST) begin
      VALVE_CLOSE <= 1'b0;
    end else if (CE) begin
      if (cycle_start || err_clear) begin
        VALVE_CLOSE <= 1'b0;
      end
      if (verdict_err && hi_live) begin
        VALVE_CLOSE <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      BUZZER <= 1'b0;
    end else if (CE) begin
      BUZZER <= any_err || WARNING;
    end
  end

  // ==========================================================
  // angle report, captured at judgment
  // the stop angle only matters for angle control and is reserved: not read
  always_ff @(posedge CLK) begin
    if (RST) begin
      REPORT_MASK <= `FAJ_RPT_SEL0;
      REPORT_IDLE_ANGLE <= `FAJ_CNT_ZERO;
      REPORT_SEAT_ANGLE <= `FAJ_CNT_ZERO;
      REPORT_FINAL_ANGLE <= `FAJ_CNT_ZERO;
    end else if (CE && judge_now) begin
      REPORT_MASK <= report_mask(ANGLE_REPORT_SELECT, CONTROL_STRATEGY);
      REPORT_IDLE_ANGLE <= ai.free_cnt;
      REPORT_SEAT_ANGLE <= ai.seat_cnt;
      REPORT_FINAL_ANGLE <= ai.final_cnt;
    end
  end
endmodule

// file: bench/faj_judge_chk.sv
/*
  Concurrent checks on the ports of the angle judgment block.
  Assumes one clock, CE held high, settings steady while a cycle runs.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

module faj_judge_chk (
  // clock, reset, strobes
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_IN,
  input wire logic JUDGE_STROBE,
  // settings
  input wire logic [`FAJ_ANG_W-1:0] FINAL_ANGLE_MIN,
  input wire logic [`FAJ_ANG_W-1:0] FINAL_ANGLE_MAX,
  input wire logic SEATING_ANGLE_CHECK_ENABLE,
  input wire logic [`FAJ_ANG_W-1:0] SEATING_ANGLE_MIN,
  input wire logic [`FAJ_ANG_W-1:0] SEATING_ANGLE_MAX,
  input wire logic [1:0] IDLE_ROTATION_CHECK_SELECT,
  input wire logic [1:0] ANGLE_VERDICT_SELECT,
  // verdict outputs
  input wire logic FAIL_OUTPUT,
  input wire logic PASS_OUTPUT,
  input wire logic COUNT_DOWN,
  input wire logic VALVE_CLOSE,
  input wire logic BUZZER,
  input wire logic WARNING,
  // error flags
  input wire logic FINAL_LOW_ERR,
  input wire logic FINAL_HIGH_ERR,
  input wire logic SNUG_TORQUE_ERR,
  input wire logic SEAT_LOW_ERR,
  input wire logic SEAT_HIGH_ERR,
  input wire logic IDLE_ROT_ERR
);
  logic [5:0] errs;
  assign errs = {FINAL_LOW_ERR, FINAL_HIGH_ERR, SNUG_TORQUE_ERR, SEAT_LOW_ERR, SEAT_HIGH_ERR, IDLE_ROT_ERR};

  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ==========================================
  // steps
  // key long enough to pass the 3-stage sync with margin
  sequence key_held;
    RESET_IN [*7];
  endsequence
  sequence count_step;
    COUNT_DOWN ##1 !COUNT_DOWN;
  endsequence

  // ==========================================
  // properties
  a_fail_follows: assert property (FAIL_OUTPUT == |$past(errs))
    else $error("fail output not the or of errors");
  a_buzz_follows: assert property (BUZZER == (|$past(errs) || $past(WARNING)))
    else $error("buzzer not following errors");
  a_key_clears: assert property (key_held |-> errs == 6'h00 ##1 !FAIL_OUTPUT)
    else $error("reset key left an error");
  a_pass_counts: assert property ($rose(PASS_OUTPUT) |-> (!FAIL_OUTPUT && $past(JUDGE_STROBE, 2)) ##0 count_step)
    else $error("pass without single count-down");
  a_low_judged: assert property ($rose(FINAL_LOW_ERR) |-> $past(JUDGE_STROBE) && FINAL_ANGLE_MIN != `FAJ_ANG_OFF)
    else $error("angle low raised wrongly");
  a_high_valve: assert property ($rose(FINAL_HIGH_ERR) |-> VALVE_CLOSE && FINAL_ANGLE_MAX != `FAJ_ANG_OFF)
    else $error("angle high without valve");
  a_seat_low: assert property ($rose(SEAT_LOW_ERR) |-> SEATING_ANGLE_CHECK_ENABLE && SEATING_ANGLE_MIN != `FAJ_ANG_OFF)
    else $error("snug angle low raised wrongly");
  a_seat_high: assert property ($rose(SEAT_HIGH_ERR) |-> SEATING_ANGLE_CHECK_ENABLE && SEATING_ANGLE_MAX != `FAJ_ANG_OFF)
    else $error("snug angle high raised wrongly");
  a_verdict_err: assert property ($rose(SNUG_TORQUE_ERR || SEAT_LOW_ERR || FINAL_LOW_ERR) |-> ANGLE_VERDICT_SELECT == `FAJ_SEL_ERR)
    else $error("error raised outside error mode");
  a_idle_err: assert property ($rose(IDLE_ROT_ERR) |-> $past(JUDGE_STROBE) && IDLE_ROTATION_CHECK_SELECT == `FAJ_SEL_ERR)
    else $error("free run error raised wrongly");
endmodule

// file: bench/faj_tool_model.sv
/*
  Behavioural tool: trigger, one encoder pulse per degree, torque steps.
  Assumes the bench pulses go with the counts already steady.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

module faj_tool_model (
  // control from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_free,
  input wire logic [7:0] n_seat,
  input wire logic [7:0] n_final,
  input wire logic valve,
  // tool side
  output logic trig,
  output logic pulse,
  output logic [`FAJ_TRQ_W-1:0] torque,
  output logic busy
);
  // ==========================================
  // spindle
  // levels held 4 cycles so the 3-stage sync never drops a degree
  task automatic turn(input logic [7:0] n);
    for (int i = 0; i < n; i++) begin
      if (valve === 1'b1) break; // closed valve stops the spindle
      pulse <= 1'b1;
      repeat (4) @(posedge clk);
      pulse <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  initial begin
    trig = 1'b0;
    pulse = 1'b0;
    torque = 14'h0000;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        torque <= 14'h0000;
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        turn(n_free);
        torque <= 14'h00C8; // above start, below snug level
        repeat (2) @(posedge clk);
        turn(n_seat);
        torque <= 14'h07D0; // past snug level, below cut
        repeat (2) @(posedge clk);
        turn(n_final);
        repeat (6) @(posedge clk);
        trig <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: bench/test_fastening_angle_judgment.sv
/*
  Self-checking bench: tightening cycles through the tool model, then
  verdict flags and reported angles. Assumes CE high throughout.
*/
`timescale 1ns/1ps
`include "faj_params.svh"

bind faj_judge faj_judge_chk i_faj_judge_chk (.*);

module test_fastening_angle_judgment;
  logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, TRIGGER_IN, ANGLE_PULSE_IN;
  logic RESET_IN = 1'b0, SNUG_TIMER_DONE = 1'b0, JUDGE_STROBE = 1'b0;
  logic [`FAJ_TRQ_W-1:0] TORQUE_VALUE, START_TORQUE = 14'h0064, CUT_TORQUE = 14'h1388;
  logic [`FAJ_TRQ_W-1:0] SEATING_TORQUE_LEVEL = 14'h03E8, IDLE_ROTATION_MIN = 14'h0000;
  logic [`FAJ_ANG_W-1:0] FINAL_ANGLE_MIN = 10'h005, FINAL_ANGLE_MAX = 10'h014, STOP_ANGLE_VALUE = 10'h3E7;
  logic [`FAJ_ANG_W-1:0] SEATING_ANGLE_MIN = 10'h000, SEATING_ANGLE_MAX = 10'h3E7;
  logic [1:0] ANGLE_REPORT_SELECT = 2'h0, IDLE_ROTATION_CHECK_SELECT = 2'h0, ANGLE_VERDICT_SELECT = 2'h1;
  logic SEATING_ANGLE_CHECK_ENABLE = 1'b0, SNUG_TORQUE_CHECK_ENABLE = 1'b0;
  logic LIMIT_AUTO_RESET = 1'b0, FASTEN_ERR_AUTO_CLEAR = 1'b0;
  logic [2:0] CONTROL_STRATEGY = 3'h0, REPORT_MASK;
  logic FAIL_OUTPUT, PASS_OUTPUT, COUNT_DOWN, VALVE_CLOSE, BUZZER, WARNING;
  logic FINAL_LOW_ERR, FINAL_HIGH_ERR, SNUG_TORQUE_ERR, SEAT_LOW_ERR, SEAT_HIGH_ERR, IDLE_ROT_ERR;
  logic [`FAJ_CNT_W-1:0] REPORT_IDLE_ANGLE, REPORT_SEAT_ANGLE, REPORT_FINAL_ANGLE;
  logic go = 1'b0, busy;
  logic [7:0] n_f = 8'h00, n_s = 8'h00, n_e = 8'h00;
  logic [4:0] rpt_in [6] = '{5'h14, 5'h15, 5'h16, 5'h17, 5'h1B, 5'h03};
  logic [2:0] rpt_exp [6] = '{`FAJ_RPT_SEL0, `FAJ_RPT_SEL1, `FAJ_RPT_SEL2, `FAJ_RPT_SEL3, `FAJ_RPT_SEL3, `FAJ_RPT_SEL0};
  int bad_count = 0, comparisons = 0, cyc = 0, cd_n = 0, cd0 = 0;

  always #12.5 CLK = ~CLK;

  faj_judge i_faj_judge (.*);
  faj_tool_model i_faj_tool_model (.clk(CLK), .go(go), .n_free(n_f), .n_seat(n_s), .n_final(n_e),
    .valve(VALVE_CLOSE), .trig(TRIGGER_IN), .pulse(ANGLE_PULSE_IN), .torque(TORQUE_VALUE), .busy(busy));

  // ==========================================
  // tasks
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // o = fail, pass, warning, valve, buzzer; e = low, high, snug torque, seat low, seat high, free run
  task automatic verdict(input logic [4:0] o, input logic [5:0] e);
    chk_v({2'b00, FAIL_OUTPUT, PASS_OUTPUT, WARNING, VALVE_CLOSE, BUZZER, FINAL_LOW_ERR, FINAL_HIGH_ERR,
      SNUG_TORQUE_ERR, SEAT_LOW_ERR, SEAT_HIGH_ERR, IDLE_ROT_ERR, (cd_n - cd0 == 1)}, {2'b00, o, e, o[3]});
    cd0 = cd_n;
  endtask

  // one tightening cycle, then the judgment strobe once the spindle has stopped
  task automatic run(input logic [7:0] f, input logic [7:0] s, input logic [7:0] e);
    @(posedge CLK);
    n_f <= f;
    n_s <= s;
    n_e <= e;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (2) @(posedge CLK);
    while (busy === 1'b1) @(posedge CLK);
    JUDGE_STROBE <= 1'b1;
    @(posedge CLK);
    JUDGE_STROBE <= 1'b0;
    repeat (4) @(posedge CLK);
    #1;
  endtask

  task automatic press();
    @(posedge CLK);
    RESET_IN <= 1'b1; // key held well past the sync depth
    repeat (8) @(posedge CLK);
    RESET_IN <= 1'b0;
    repeat (6) @(posedge CLK);
    #1;
  endtask

  // count-down pulses and the hang limit
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (COUNT_DOWN === 1'b1) cd_n <= cd_n + 1;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b01000, 6'h00);
    chk_v(REPORT_IDLE_ANGLE, 14'h0005);
    chk_v(REPORT_SEAT_ANGLE, 14'h0005);
    chk_v(REPORT_FINAL_ANGLE, 14'h000A);
    run(8'h05, 8'h05, 8'h03);
    verdict(5'b10001, 6'h20);
    #1000;
    verdict(5'b10001, 6'h20);
    press();
    verdict(5'b00000, 6'h00);
    FINAL_ANGLE_MIN <= 10'h000;
    STOP_ANGLE_VALUE <= 10'h000;
    run(8'h05, 8'h05, 8'h03);
    verdict(5'b01000, 6'h00);
    FINAL_ANGLE_MIN <= 10'h005;
    run(8'h05, 8'h05, 8'h28);
    verdict(5'b10011, 6'h10);
    chk_v(REPORT_FINAL_ANGLE, 14'h0015);
    LIMIT_AUTO_RESET <= 1'b1;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b01000, 6'h00);
    FINAL_ANGLE_MAX <= 10'h000;
    run(8'h05, 8'h05, 8'h28);
    verdict(5'b01000, 6'h00);
    FINAL_ANGLE_MAX <= 10'h014;
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_WARN;
    run(8'h05, 8'h05, 8'h19);
    verdict(5'b01101, 6'h00);
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_OFF;
    run(8'h05, 8'h05, 8'h03);
    verdict(5'b01000, 6'h00);
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_ERR;
    SNUG_TORQUE_CHECK_ENABLE <= 1'b1;
    SNUG_TIMER_DONE <= 1'b1;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b10001, 6'h08);
    SNUG_TIMER_DONE <= 1'b0;
    FASTEN_ERR_AUTO_CLEAR <= 1'b1;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b01000, 6'h00);
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_WARN;
    SNUG_TIMER_DONE <= 1'b1;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b01101, 6'h00);
    SNUG_TIMER_DONE <= 1'b0;
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_ERR;
    SEATING_ANGLE_CHECK_ENABLE <= 1'b1;
    SEATING_ANGLE_MIN <= 10'h004;
    SEATING_ANGLE_MAX <= 10'h006;
    run(8'h05, 8'h02, 8'h0A);
    verdict(5'b10001, 6'h04);
    run(8'h05, 8'h08, 8'h0A);
    verdict(5'b10001, 6'h02);
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_WARN;
    run(8'h05, 8'h08, 8'h0A);
    verdict(5'b01101, 6'h00);
    ANGLE_VERDICT_SELECT <= `FAJ_SEL_ERR;
    SEATING_ANGLE_MIN <= 10'h000;
    SEATING_ANGLE_MAX <= 10'h000;
    run(8'h05, 8'h02, 8'h0A);
    verdict(5'b01000, 6'h00);
    IDLE_ROTATION_CHECK_SELECT <= `FAJ_SEL_ERR;
    IDLE_ROTATION_MIN <= 14'h0004;
    run(8'h02, 8'h05, 8'h0A);
    verdict(5'b10001, 6'h01);
    IDLE_ROTATION_CHECK_SELECT <= `FAJ_SEL_WARN;
    run(8'h02, 8'h05, 8'h0A);
    verdict(5'b01101, 6'h00);
    IDLE_ROTATION_CHECK_SELECT <= `FAJ_SEL_ERR;
    IDLE_ROTATION_MIN <= 14'h270F;
    run(8'h05, 8'h05, 8'h0A);
    verdict(5'b10001, 6'h01);
    IDLE_ROTATION_CHECK_SELECT <= `FAJ_SEL_OFF;
    FINAL_ANGLE_MIN <= 10'h000;
    for (int i = 0; i < 6; i++) begin
      {CONTROL_STRATEGY, ANGLE_REPORT_SELECT} <= rpt_in[i];
      run(8'h01, 8'h01, 8'h01);
      chk_v({11'h000, REPORT_MASK}, {11'h000, rpt_exp[i]});
    end
    summarize();
  end
endmodule
